/* File: rtl/ebs_block_memory.sv */
// embedded block memory: array, two ports, shape logic and register slave
`timescale 1ns/10ps
module ebs_block_memory (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic port_a_clock,
   input wire logic port_b_clock,
   input wire ebs_pkg::ebs_port_req_t port_a_req,
   input wire ebs_pkg::ebs_port_req_t port_b_req,
   output logic [35:0] port_a_dout,
   output logic [35:0] port_b_dout,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import ebs_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] lanes_log2(input logic [3:0] w);
      case (w)
         W_X1: lanes_log2 = 3'd5;
         W_X2: lanes_log2 = 3'd4;
         W_X4, W_X9: lanes_log2 = 3'd3 - {2'b00, w == W_X9};
         W_X8: lanes_log2 = 3'd2;
         W_X16, W_X18: lanes_log2 = 3'd1;
         default: lanes_log2 = 3'd0;
      endcase
   endfunction : lanes_log2

   function automatic logic [5:0] bits_of(input logic [3:0] w);
      case (w)
         W_X1: bits_of = 6'd1;
         W_X2: bits_of = 6'd2;
         W_X4: bits_of = 6'd4;
         W_X8: bits_of = 6'd8;
         W_X16: bits_of = 6'd16;
         W_X32: bits_of = 6'd32;
         W_X9: bits_of = 6'd9;
         W_X18: bits_of = 6'd18;
         default: bits_of = 6'd36;
      endcase
   endfunction : bits_of

   function automatic logic has_ninth(input logic [3:0] w);
      has_ninth = (w == W_X9) || (w == W_X18) || (w == W_X36);
   endfunction : has_ninth

   // plain shapes use eight of the nine bits in every byte
   function automatic logic [31:0] drop_ninth(input logic [35:0] x);
      drop_ninth = {x[34:27], x[25:18], x[16:9], x[7:0]};
   endfunction : drop_ninth

   function automatic logic [35:0] add_ninth(input logic [31:0] x);
      add_ninth = {1'b0, x[31:24], 1'b0, x[23:16], 1'b0, x[15:8], 1'b0, x[7:0]};
   endfunction : add_ninth

   function automatic logic [35:0] ones(input logic [5:0] n);
      logic [36:0] t;
      t = (37'h1 << n) - 37'h1;
      ones = t[35:0];
   endfunction : ones

   function automatic logic [35:0] extract(input logic [35:0] word, input logic [3:0] w,
                                           input logic [5:0] sh);
      logic [35:0] l;
      l = has_ninth(w) ? word : {4'h0, drop_ninth(word)};
      extract = (l >> sh) & ones(bits_of(w));
   endfunction : extract

   function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      be_merge = (o & ~m) | (n & m);
   endfunction : be_merge

   // ------------------------------------------------------------
   // configuration state
   // ------------------------------------------------------------
   ebs_ctrl_t ctrl_q;
   logic [3:0] width_a_q;
   logic [3:0] width_b_q;
   logic [8:0] load_addr_q;
   logic [3:0] load_hi_q;
   ebs_bus_state_t bus_q;
   logic [31:0] avs_readdata_q;
   logic avs_waitrequest_q;
   logic wr_go;
   logic load_go;
   logic cfg_ok;
   logic active;
   logic [31:0] reg_rd;
   logic [31:0] ctrl_wr;
   logic [31:0] width_wr;
   logic [31:0] laddr_wr;

   // shape legality per mode
   always_comb
   begin
      cfg_ok = 1'b1;
      case (ctrl_q.mode)
         EBS_TRUE_DUAL:
            cfg_ok = (width_a_q <= W_X36) && (width_b_q <= W_X36)
                     && (width_a_q != W_X32) && (width_a_q != W_X36)
                     && (width_b_q != W_X32) && (width_b_q != W_X36)
                     && (has_ninth(width_a_q) == has_ninth(width_b_q));
         EBS_SIMPLE_DUAL:
            cfg_ok = (width_a_q <= W_X36) && (width_b_q <= W_X36)
                     && (has_ninth(width_a_q) == has_ninth(width_b_q))
                     && ((width_b_q != W_X36) || (width_a_q == W_X36));
         default:
            cfg_ok = (width_a_q <= W_X36);
      endcase
   end

   assign active = ctrl_q.run & cfg_ok;

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   assign wr_go = (bus_q == BUS_ACK) & avs_write;
   assign load_go = wr_go & (avs_address == REG_LOAD_LO) & ~ctrl_q.run;

   always_comb
   begin
      case (avs_address)
         REG_CTRL: reg_rd = {22'h0, ctrl_q};
         REG_WIDTH: reg_rd = {24'h0, width_b_q, width_a_q};
         REG_STATUS: reg_rd = {30'h0, cfg_ok, ctrl_q.run};
         REG_LOAD_ADDR: reg_rd = {23'h0, load_addr_q};
         REG_LOAD_HI: reg_rd = {28'h0, load_hi_q};
         default: reg_rd = 32'h0000_0000;
      endcase
      ctrl_wr = be_merge({22'h0, ctrl_q}, avs_writedata, avs_byteenable);
      width_wr = be_merge({24'h0, width_b_q, width_a_q}, avs_writedata, avs_byteenable);
      laddr_wr = be_merge({23'h0, load_addr_q}, avs_writedata, avs_byteenable);
   end

   // one wait cycle, then the answer stands for one edge
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bus_q <= BUS_IDLE;
         avs_waitrequest_q <= 1'b1;
         avs_readdata_q <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         case (bus_q)
            BUS_IDLE:
               if (avs_read || avs_write)
               begin
                  bus_q <= BUS_ACK;
                  avs_waitrequest_q <= 1'b0;
                  avs_readdata_q <= avs_read ? reg_rd : 32'h0000_0000;
               end
            BUS_ACK:
            begin
               bus_q <= BUS_IDLE;
               avs_waitrequest_q <= 1'b1;
            end
            default:
            begin
               bus_q <= BUS_IDLE;
               avs_waitrequest_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q <= ebs_ctrl_t'(CTRL_RESET);
         width_a_q <= WIDTH_RESET[3:0];
         width_b_q <= WIDTH_RESET[7:4];
      end
      else if (clk_en && wr_go)
      begin
         if (avs_address == REG_CTRL)
            ctrl_q <= ebs_ctrl_t'(ctrl_wr[CTRL_W-1:0]);
         if (avs_address == REG_WIDTH)
         begin
            width_a_q <= width_wr[WIDTH_A_LSB +: 4];
            width_b_q <= width_wr[WIDTH_B_LSB +: 4];
         end
      end
   end

   // contents loaded while stopped, before user traffic starts
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         load_addr_q <= 9'h000;
         load_hi_q <= 4'h0;
      end
      else if (clk_en && wr_go)
      begin
         if (avs_address == REG_LOAD_ADDR)
            load_addr_q <= laddr_wr[IDX_W-1:0];
         if (avs_address == REG_LOAD_HI)
            load_hi_q <= be_merge({28'h0, load_hi_q}, avs_writedata, avs_byteenable) >> 0 == 32'h0
                         ? 4'h0 : avs_writedata[3:0] & {4{avs_byteenable[0]}} | load_hi_q
                           & {4{~avs_byteenable[0]}};
         if (load_go)
            load_addr_q <= load_addr_q + 9'h001;
      end
   end

   // ------------------------------------------------------------
   // array and ports
   // ------------------------------------------------------------
   logic [35:0] mem [MEM_DEPTH];
   ebs_port_req_t req [2];
   logic [8:0] idx [2];
   logic [35:0] nw [2];
   logic [35:0] dout_q [2];
   logic [1:0] wr;
   logic [1:0] pclk_raw;
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;
   logic [1:0] pedge;

   assign req[0] = port_a_req;
   assign req[1] = port_b_req;
   assign pclk_raw = {port_b_clock, port_a_clock};

   // port clocks are outside strobes: two flops before anything looks
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_q <= 2'b00;
         s2_q <= 2'b00;
         s3_q <= 2'b00;
      end
      else if (clk_en)
      begin
         s1_q <= pclk_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // single-port uses one clock; shared option ties B to A clock
   assign pedge[0] = s2_q[0] & ~s3_q[0];
   assign pedge[1] = (ctrl_q.shared_clk ? s2_q[0] & ~s3_q[0] : s2_q[1] & ~s3_q[1]);

   // A write lands first so a B write to the same word merges over it
   always_ff @(posedge ref_clk)
   begin
      if (clk_en)
      begin
         if (load_go)
            mem[load_addr_q] <= {load_hi_q, avs_writedata};
         if (wr[0])
            mem[idx[0]] <= nw[0];
         if (wr[1])
            mem[idx[1]] <= nw[1];
      end
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_port
      logic [3:0] wc;
      logic [5:0] wb;
      logic [5:0] sh;
      logic [4:0] lane;
      logic [35:0] rd;
      logic [35:0] base;
      logic [35:0] mlog;
      logic [35:0] dlog;
      logic [35:0] mph;
      logic [35:0] dph;
      logic [3:0] b4;
      logic can_rd;
      logic can_wr;
      logic fire;
      logic pipe;
      ebs_wmode_t wm;
      logic [35:0] arr_d;
      logic [35:0] arr_q;

      always_comb
      begin
         wc = (g == 0) ? width_a_q : width_b_q;
         wb = bits_of(wc);
         lane = req[g].addr[4:0] & ((5'd1 << lanes_log2(wc)) - 5'd1);
         sh = 6'(lane * wb);
         idx[g] = 9'(req[g].addr >> lanes_log2(wc));
         rd = mem[idx[g]];
         base = (g == 1 && wr[0] && idx[0] == idx[g]) ? nw[0] : rd;
         if (wb >= 6'd32)
            b4 = req[g].be;
         else if (wb >= 6'd16)
            b4 = lane[0] ? {req[g].be[1:0], 2'b00} : {2'b00, req[g].be[1:0]};
         else
            b4 = 4'hF;
         mlog = ones(wb) << sh;
         dlog = (req[g].wdata & ones(wb)) << sh;
         if (has_ninth(wc))
         begin
            mph = mlog & {{9{b4[3]}}, {9{b4[2]}}, {9{b4[1]}}, {9{b4[0]}}};
            dph = dlog;
         end
         else
         begin
            mph = add_ninth(mlog[31:0] & {{8{b4[3]}}, {8{b4[2]}}, {8{b4[1]}}, {8{b4[0]}}});
            dph = add_ninth(dlog[31:0]);
         end
         nw[g] = (base & ~mph) | (dph & mph);
         if (g == 0)
         begin
            can_rd = ctrl_q.mode != EBS_SIMPLE_DUAL;
            can_wr = ctrl_q.mode != EBS_ROM;
            pipe = ctrl_q.pipe_a;
            if (ctrl_q.mode == EBS_SINGLE)
               wm = ctrl_q.wmode_a;
            else if (ctrl_q.mode == EBS_TRUE_DUAL && ctrl_q.wmode_a == WR_THROUGH)
               wm = WR_THROUGH;
            else
               wm = WR_NORMAL;
         end
         else
         begin
            can_rd = ctrl_q.mode == EBS_TRUE_DUAL || ctrl_q.mode == EBS_SIMPLE_DUAL;
            can_wr = ctrl_q.mode == EBS_TRUE_DUAL;
            pipe = ctrl_q.pipe_b;
            wm = (ctrl_q.wmode_b == WR_THROUGH) ? WR_THROUGH : WR_NORMAL;
         end
         // one access per edge: the request is either a read or a write
         fire = pedge[g] & req[g].en & active & (req[g].we ? can_wr : can_rd);
         wr[g] = fire & req[g].we;
         arr_d = arr_q;
         if (fire && !req[g].we)
            arr_d = extract(rd, wc, sh);
         else if (fire)
         begin
            case (wm)
               WR_THROUGH: arr_d = extract(nw[g], wc, sh);
               WR_OLD_FIRST: arr_d = extract(rd, wc, sh);
               default: arr_d = arr_q;
            endcase
         end
      end

      // array output register, then optional pipeline stage
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            arr_q <= 36'h0_0000_0000;
            dout_q[g] <= 36'h0_0000_0000;
         end
         else if (clk_en && pedge[g])
         begin
            arr_q <= arr_d;
            dout_q[g] <= pipe ? arr_q : arr_d;
         end
      end
   end

   assign port_a_dout = dout_q[0];
   assign port_b_dout = dout_q[1];
   assign avs_readdata = avs_readdata_q;
   assign avs_waitrequest = avs_waitrequest_q;

endmodule : ebs_block_memory

/* File: pkg/ebs_pkg.sv */
// shared constants, types and register map of the embedded block memory
package ebs_pkg;

   // ------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------
   localparam int MEM_BITS = 18432;
   localparam int ROM_BITS = 16384;
   localparam int MEM_DEPTH = 512;
   localparam int WORD_W = 36;
   localparam int ADDR_W = 14;
   localparam int IDX_W = 9;
   localparam int CLK_PERIOD_NS = 8;
   // two sync flops plus one edge flop before a port clock edge acts
   localparam int PORT_EDGE_LATENCY = 3;

   // ------------------------------------------------------------
   // register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam int AVS_ADDR_W = 5;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_WIDTH = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_LOAD_ADDR = 5'h0C;
   localparam logic [4:0] REG_LOAD_HI = 5'h10;
   localparam logic [4:0] REG_LOAD_LO = 5'h14;
   localparam int CTRL_W = 10;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam int WIDTH_A_LSB = 0;
   localparam int WIDTH_B_LSB = 4;
   localparam logic [7:0] WIDTH_RESET = 8'h00;
   localparam int STAT_RUN = 0;
   localparam int STAT_CFG_OK = 1;

   // ------------------------------------------------------------
   // shape codes
   // ------------------------------------------------------------
   localparam logic [3:0] W_X1 = 4'h0;
   localparam logic [3:0] W_X2 = 4'h1;
   localparam logic [3:0] W_X4 = 4'h2;
   localparam logic [3:0] W_X8 = 4'h3;
   localparam logic [3:0] W_X16 = 4'h4;
   localparam logic [3:0] W_X32 = 4'h5;
   localparam logic [3:0] W_X9 = 4'h6;
   localparam logic [3:0] W_X18 = 4'h7;
   localparam logic [3:0] W_X36 = 4'h8;

   typedef enum logic [1:0] {
      EBS_SINGLE = 2'h0,
      EBS_TRUE_DUAL = 2'h1,
      EBS_SIMPLE_DUAL = 2'h2,
      EBS_ROM = 2'h3
   } ebs_mode_t;

   typedef enum logic [1:0] {
      WR_NORMAL = 2'h0,
      WR_THROUGH = 2'h1,
      WR_OLD_FIRST = 2'h2
   } ebs_wmode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } ebs_bus_state_t;

   // run is bit 0, wmode_b ends at bit 9
   typedef struct packed {
      ebs_wmode_t wmode_b;
      ebs_wmode_t wmode_a;
      logic pipe_b;
      logic pipe_a;
      logic shared_clk;
      ebs_mode_t mode;
      logic run;
   } ebs_ctrl_t;

   typedef struct packed {
      logic en;
      logic we;
      logic [13:0] addr;
      logic [35:0] wdata;
      logic [3:0] be;
   } ebs_port_req_t;

endpackage : ebs_pkg

/* File: tb/ebs_fabric_port.sv */
// fabric logic model that drives one memory port
`timescale 1ns/10ps
module ebs_fabric_port (
   input wire logic ref_clk,
   output logic port_clock,
   output ebs_pkg::ebs_port_req_t req,
   input wire logic [35:0] dout
);
   import ebs_pkg::*;

   initial
   begin
      port_clock = 1'b0;
      req = '0;
   end

   // ----------------------------------------
   // one access per port clock edge
   // ----------------------------------------
   // slow stretches both clock phases; callers keep the two ports on
   // different addresses in one cycle
   task automatic access(input logic we, input logic [13:0] addr, input logic [35:0] wd,
                         input logic [3:0] be, input int slow);
      @(posedge ref_clk);
      req <= '{en: 1'b1, we: we, addr: addr, wdata: wd, be: be};
      port_clock <= 1'b1;
      repeat (4 + slow) @(posedge ref_clk);
      port_clock <= 1'b0;
      // released lines show inverted values, not the old ones
      req <= '{en: 1'b0, we: ~we, addr: ~addr, wdata: ~wd, be: ~be};
      repeat (4 + slow) @(posedge ref_clk);
   endtask : access
endmodule : ebs_fabric_port

/* File: tb/ebs_block_memory_asserts.sv */
// port assertions for the embedded block memory
`timescale 1ns/10ps
module ebs_block_memory_asserts (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic port_a_clock,
   input wire logic port_b_clock,
   input wire ebs_pkg::ebs_port_req_t port_a_req,
   input wire ebs_pkg::ebs_port_req_t port_b_req,
   input wire logic [35:0] port_a_dout,
   input wire logic [35:0] port_b_dout,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   import ebs_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   bus_answer_a: assert property (clk_en && avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
      else $error("request not answered");
   no_spurious_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("answer without request");
   unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > REG_LOAD_LO
                                     |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!((avs_read || avs_write) && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without request");
   // an accepted write clears the read data word; a read wins if both are up
   write_clear_a: assert property (clk_en && avs_write && !avs_read && avs_waitrequest
                                   |=> avs_readdata == 32'h0000_0000)
      else $error("read data not cleared by write");
   reset_idle_a: assert property ($rose(reset_n) |-> avs_waitrequest && port_a_dout == 36'h0_0000_0000)
      else $error("not idle after reset");

   // ----------------------------------------
   // memory ports: output moves only three edges after a port clock rise
   // ----------------------------------------
   a_edge_a: assert property ($changed(port_a_dout) |-> $past(port_a_clock, 3) && !$past(port_a_clock, 4))
      else $error("port a data moved off its edge");
   b_edge_a: assert property ($changed(port_b_dout) |-> $past(port_b_clock, 3) && !$past(port_b_clock, 4))
      else $error("port b data moved off its edge");

   cover property (avs_read && !avs_waitrequest);
   cover property ($changed(port_a_dout));
   cover property ($changed(port_b_dout));
endmodule : ebs_block_memory_asserts

bind ebs_block_memory ebs_block_memory_asserts u_asserts (
   .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
   .port_a_clock(port_a_clock), .port_b_clock(port_b_clock),
   .port_a_req(port_a_req), .port_b_req(port_b_req),
   .port_a_dout(port_a_dout), .port_b_dout(port_b_dout),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

/* File: tb/embedded_block_sram_tb.sv */
// self-checking bench for the embedded block memory
`timescale 1ns/10ps
module embedded_block_sram_tb;
   import ebs_pkg::*;
   localparam logic [35:0] D1 = 36'h1_2345_6789;
   localparam logic [35:0] D2 = 36'hF_FFFF_FFFF;
   localparam logic [35:0] D3 = 36'h5_A5A5_A5A5;
   localparam logic [35:0] MSK = 36'h0_07FC_01FF;
   localparam logic [35:0] MRG = (D2 & MSK) | (D1 & ~MSK);
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic pa_clk;
   logic pb_clk;
   ebs_port_req_t pa_req;
   ebs_port_req_t pb_req;
   logic [35:0] pa_dout;
   logic [35:0] pb_dout;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int bad_count = 0;
   int checks = 0;

   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

   ebs_block_memory uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
      .port_a_clock(pa_clk), .port_b_clock(pb_clk), .port_a_req(pa_req), .port_b_req(pb_req),
      .port_a_dout(pa_dout), .port_b_dout(pb_dout), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
   );
   ebs_fabric_port fa (.ref_clk(ref_clk), .port_clock(pa_clk), .req(pa_req), .dout(pa_dout));
   ebs_fabric_port fb (.ref_clk(ref_clk), .port_clock(pb_clk), .req(pb_req), .dout(pb_dout));

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: register %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: port data %h expected %h", $time, got, exp);
      end
   endtask : chk36

   // holds the request until waitrequest is seen low; the watchdog ends a hang
   task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
      @(posedge ref_clk);
      avs_address <= adr;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= wd;
      do
         @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rc(input logic [4:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0000_0000);
      chk32(avs_readdata, exp);
   endtask : rc

   task automatic cfg(input ebs_mode_t m, input logic [3:0] wa, input logic [3:0] wb,
                      input logic pa, input ebs_wmode_t wm);
      ebs_ctrl_t c;
      c = '{wmode_b: wm, wmode_a: wm, pipe_b: 1'b0, pipe_a: pa, shared_clk: 1'b0, mode: m, run: 1'b1};
      bus(1'b1, REG_CTRL, 32'h0000_0000);
      bus(1'b1, REG_WIDTH, {24'h00_0000, wb, wa});
      bus(1'b1, REG_CTRL, {22'h00_0000, c});
   endtask : cfg

   task automatic okchk(input ebs_mode_t m, input logic [3:0] wa, input logic [3:0] wb, input logic ok);
      cfg(m, wa, wb, 1'b0, WR_NORMAL);
      rc(REG_STATUS, {30'h0000_0000, ok, 1'b1});
   endtask : okchk

   task automatic wa(input logic [13:0] a, input logic [35:0] d, input logic [3:0] be);
      fa.access(1'b1, a, d, be, 0);
   endtask : wa

   task automatic ra(input logic [13:0] a);
      fa.access(1'b0, a, 36'h0_0000_0000, 4'h0, 1);
   endtask : ra

   task automatic rb(input logic [13:0] a);
      fb.access(1'b0, a, 36'h0_0000_0000, 4'h0, 3);
   endtask : rb

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      chk36(pa_dout, 36'h0_0000_0000);
      rc(REG_CTRL, {22'h00_0000, CTRL_RESET});
      rc(REG_WIDTH, {24'h00_0000, WIDTH_RESET});
      bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
      rc(5'h1C, 32'h0000_0000);
      cfg(EBS_SINGLE, W_X36, W_X36, 1'b0, WR_THROUGH);
      wa(14'h0005, D1, 4'hF);
      chk36(pa_dout, D1);
      wa(14'h0005, D2, 4'h5);
      ra(14'h0005);
      chk36(pa_dout, MRG);
      cfg(EBS_SINGLE, W_X36, W_X36, 1'b0, WR_NORMAL);
      wa(14'h0006, D3, 4'hF);
      chk36(pa_dout, MRG);
      cfg(EBS_SINGLE, W_X36, W_X36, 1'b0, WR_OLD_FIRST);
      wa(14'h0006, D1, 4'hF);
      chk36(pa_dout, D3);
      cfg(EBS_SINGLE, W_X36, W_X36, 1'b1, WR_NORMAL);
      ra(14'h0006);
      ra(14'h0005);
      chk36(pa_dout, D1);
      ra(14'h0005);
      chk36(pa_dout, MRG);
      cfg(EBS_SIMPLE_DUAL, W_X36, W_X9, 1'b0, WR_NORMAL);
      wa(14'h0002, D3, 4'hF);
      ra(14'h0002);
      chk36(pa_dout, MRG);
      fork
         wa(14'h0003, D1, 4'hF);
         rb(14'h0009);
      join
      chk36(pb_dout, {27'h000_0000, D3[17:9]});
      fb.access(1'b1, 14'h0009, 36'h0_0000_0000, 4'hF, 0);
      rb(14'h0009);
      chk36(pb_dout, {27'h000_0000, D3[17:9]});
      cfg(EBS_TRUE_DUAL, W_X16, W_X16, 1'b0, WR_THROUGH);
      fork
         wa(14'h0003, 36'h0_0000_BEEF, 4'h3);
         fb.access(1'b1, 14'h0004, 36'h0_0000_1234, 4'h3, 2);
      join
      chk36(pb_dout, 36'h0_0000_1234);
      fork
         ra(14'h0004);
         rb(14'h0003);
      join
      chk36(pa_dout, 36'h0_0000_1234);
      chk36(pb_dout, 36'h0_0000_BEEF);
      // shared clock: run, true dual, write-through on both; B follows A edges only
      bus(1'b1, REG_CTRL, 32'h0000_014B);
      fork
         ra(14'h0003);
         begin
            repeat (6) @(posedge ref_clk);
            rb(14'h0004);
         end
      join
      chk36(pa_dout, 36'h0_0000_BEEF);
      chk36(pb_dout, 36'h0_0000_BEEF);
      okchk(EBS_TRUE_DUAL, W_X16, W_X8, 1'b1);
      okchk(EBS_TRUE_DUAL, W_X18, W_X8, 1'b0);
      okchk(EBS_TRUE_DUAL, W_X32, W_X32, 1'b0);
      okchk(EBS_SIMPLE_DUAL, W_X36, W_X18, 1'b1);
      bus(1'b1, REG_CTRL, 32'h0000_0000);
      bus(1'b1, REG_LOAD_ADDR, 32'h0000_0007);
      bus(1'b1, REG_LOAD_HI, 32'h0000_000A);
      bus(1'b1, REG_LOAD_LO, 32'h5555_AAAA);
      cfg(EBS_ROM, W_X36, W_X36, 1'b0, WR_THROUGH);
      wa(14'h0007, D1, 4'hF);
      ra(14'h0007);
      chk36(pa_dout, 36'hA_5555_AAAA);
      summarize();
   end

   // whole run is a few hundred cycles
   initial
   begin
      #(CLK_PERIOD_NS * 20000);
      bad_count++;
      summarize();
   end
endmodule : embedded_block_sram_tb
